// ### rtl/ars_top.sv
// adc request sequencer: sources, arbiter, result store, avalon slave
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "ars_defs.svh"
// Overview of operation
// - Results are 10-bit; an 8-bit mode shortens conversion.
// - Seven dedicated plus two shared channels; shared ones go to either.
// - Sample and conversion phase lengths are software programmable.
// - Sync mode starts both converters together on two channels.
// - Trigger events start the parallel source or arm the queue.
// - Parallel source loads all requests, converts lowest channel first.
// - Queue entries convert in the order software wrote them.
// - An inserted channel runs between conversions; the sequence continues.
// - Parallel and queue sources are granted by their assigned priority level; an inserted channel always goes first.
// - Results can be limit checked or accumulated.
// - Eight result registers per converter, chainable into a FIFO.
// - Wait-for-read per result register keeps unread results intact unless accumulation is on.
// - Each cycle that stores a result pulses one request to the event transfer unit.
// - External multiplexer select lines follow the converted entry.
// - Per-pin digital input disable; unused pins stay digital inputs.
// - Converters power down when idle and wake on a request.
// - Broken-wire precharge and multiplexer test mode are provided.
module ars_top import ars_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [1:0] trig_in,
   input wire logic [9:0] ana0,
   input wire logic [9:0] ana1,
   output logic [3:0] mux_sel0,
   output logic [3:0] mux_sel1,
   output logic [2:0] ext_mux_sel,
   output logic [1:0] conv_pwr,
   output logic [1:0] bw_precharge,
   output logic mux_test,
   output logic [8:0] din_disable,
   output logic evt_req
);
   // lowest pending channel, fixed order
   function automatic logic [3:0] first_ch(input logic [8:0] m);
      logic [3:0] r;
      r = 4'h0;
      for (int i = `ARS_NCH - 1; i >= 0; i--) begin
         if (m[i]) r = 4'(i);
      end
      return r;
   endfunction
   // result register index for a channel
   function automatic logic [2:0] slot(input logic chain,
                                       input logic [2:0] wp,
                                       input logic [3:0] ch);
      return chain ? wp : ch[2:0];
   endfunction

   ars_seq_t sq_reg, sq_next;
   logic [9:0] ctrl_reg, ctrl_next;
   logic [15:0] time_reg, time_next;
   logic [8:0] pmask_reg, pmask_next, pend_reg, pend_next;
   ars_qent_t q_reg [0:3];
   ars_qent_t q_next [0:3];
   logic [2:0] qcnt_reg, qcnt_next;
   logic qgo_reg, qgo_next, insv_reg, insv_next;
   ars_qent_t ins_reg, ins_next;
   logic [3:0] prio_reg, prio_next;
   logic [1:0] trig_reg, trig_next;
   logic [9:0] lo_reg, lo_next, hi_reg, hi_next;
   logic [3:0] flag_reg, flag_next;
   logic [7:0] wfr_reg, wfr_next;
   logic [8:0] ddis_reg, ddis_next;
   ars_res_t res_reg [0:1][0:7];
   ars_res_t res_next [0:1][0:7];
   logic [7:0] val_reg [0:1];
   logic [7:0] val_next [0:1];
   logic [2:0] wp_reg [0:1];
   logic [2:0] wp_next [0:1];
   logic [2:0] rp_reg [0:1];
   logic [2:0] rp_next [0:1];
   logic [3:0] ch_reg [0:1];
   logic [3:0] ch_next [0:1];
   logic [2:0] xmux_reg, xmux_next;
   logic ack_reg, ack_next, evt_reg, evt_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [1:0] pwr_reg, pwr_next, bw_reg, bw_next;
   // converter handshake
   logic [1:0] start, busy, smp, done;
   logic [9:0] cres [0:1];
   // arbiter
   ars_src_t src;
   ars_qent_t gent;
   logic par_v, q_v, to0, to1, stall, acc, grant;
   logic [3:0] ch1;
   logic [2:0] k_slot, s_slot;
   logic [15:0] nv;
   logic [1:0] rk;

   // ----------------------------------------------------------------
   // converters
   // ----------------------------------------------------------------
   ars_conv u_conv0 (.clk(clk), .rst_n(rst_n), .start(start[0]),
      .res8(ctrl_reg[`ARS_C_RES8]), .smp_cyc(time_reg[7:0]),
      .cnv_cyc(time_reg[15:8]), .ana(ana0), .busy(busy[0]),
      .sampling(smp[0]), .done(done[0]), .result(cres[0]));
   ars_conv u_conv1 (.clk(clk), .rst_n(rst_n), .start(start[1]),
      .res8(ctrl_reg[`ARS_C_RES8]), .smp_cyc(time_reg[7:0]),
      .cnv_cyc(time_reg[15:8]), .ana(ana1), .busy(busy[1]),
      .sampling(smp[1]), .done(done[1]), .result(cres[1]));

   // ----------------------------------------------------------------
   // request arbitration and routing
   // ----------------------------------------------------------------
   always_comb begin
      par_v = |pend_reg;
      q_v = (qcnt_reg != 3'h0) && (qgo_reg || !trig_reg[1]);
      src = SRC_NONE;
      gent = 7'h00;
      if (insv_reg) begin // inserted channel goes first
         src = SRC_INS;
         gent = ins_reg;
      end else if (par_v && (!q_v || prio_reg[1:0] >= prio_reg[3:2])) begin
         src = SRC_PAR;
         gent = {xmux_reg, first_ch(pend_reg)};
      end else if (q_v) begin
         src = SRC_Q;
         gent = q_reg[0]; // oldest entry
      end
      // shared channels may go to the second converter
      to1 = ctrl_reg[`ARS_C_SYNC] ||
            (gent[3:0] >= `ARS_SHARED && ctrl_reg[`ARS_C_SH2]);
      to0 = ctrl_reg[`ARS_C_SYNC] || !to1;
      ch1 = ctrl_reg[`ARS_C_SYNC] ?
            `ARS_SHARED + {3'h0, ctrl_reg[`ARS_C_SYCH]} : gent[3:0];
      // hold off while a wait-for-read slot is unread
      acc = ctrl_reg[`ARS_C_ACC];
      stall = 1'b0;
      k_slot = slot(ctrl_reg[`ARS_C_CHAIN], wp_reg[0], gent[3:0]);
      if (to0 && wfr_reg[k_slot] && val_reg[0][k_slot] && !acc) stall = 1'b1;
      k_slot = slot(ctrl_reg[`ARS_C_CHAIN], wp_reg[1], ch1);
      if (to1 && wfr_reg[k_slot] && val_reg[1][k_slot] && !acc) stall = 1'b1;
      grant = (sq_reg == SQ_IDLE) && (src != SRC_NONE) && !stall;
      start = grant ? {to1, to0} : 2'b00;
   end

   // ----------------------------------------------------------------
   // next state of sequencer, sources, results and bus slave
   // ----------------------------------------------------------------
   always_comb begin
      sq_next = sq_reg;
      ctrl_next = ctrl_reg;
      time_next = time_reg;
      pmask_next = pmask_reg;
      pend_next = pend_reg;
      q_next = q_reg;
      qcnt_next = qcnt_reg;
      qgo_next = qgo_reg;
      insv_next = insv_reg;
      ins_next = ins_reg;
      prio_next = prio_reg;
      trig_next = trig_reg;
      lo_next = lo_reg;
      hi_next = hi_reg;
      flag_next = flag_reg;
      wfr_next = wfr_reg;
      ddis_next = ddis_reg;
      res_next = res_reg;
      val_next = val_reg;
      wp_next = wp_reg;
      rp_next = rp_reg;
      ch_next = ch_reg;
      xmux_next = xmux_reg;
      evt_next = 1'b0;
      nv = 16'h0000;
      rk = 2'h0;
      s_slot = 3'h0;
      rdat_next = rdat_reg;
      // answer one cycle after the request is seen
      ack_next = (avs_read || avs_write) && !ack_reg;
      pwr_next = busy | start;
      bw_next = ctrl_reg[`ARS_C_BWD] ? smp : 2'b00;

      // register read data captured before the answering edge
      if ((avs_read || avs_write) && !ack_reg) begin
         rdat_next = 32'h0000_0000;
         case (avs_address)
            `ARS_CTRL: rdat_next[9:0] = ctrl_reg;
            `ARS_TIME: rdat_next[15:0] = time_reg;
            `ARS_PMASK: rdat_next = {7'h00, pend_reg, 7'h00, pmask_reg};
            `ARS_QUEUE: rdat_next[2:0] = qcnt_reg;
            `ARS_INSERT: rdat_next[7:0] = {insv_reg, ins_reg};
            `ARS_PRIO: rdat_next[3:0] = prio_reg;
            `ARS_TRIG: rdat_next[1:0] = trig_reg;
            `ARS_LIMIT: rdat_next = {6'h00, hi_reg, 6'h00, lo_reg};
            `ARS_STATUS: rdat_next = {24'h0, busy, qcnt_reg[1:0], flag_reg};
            `ARS_POP0: rdat_next[15:0] = res_reg[0][rp_reg[0]];
            `ARS_POP1: rdat_next[15:0] = res_reg[1][rp_reg[1]];
            `ARS_WFR: rdat_next[7:0] = wfr_reg;
            `ARS_DDIS: rdat_next[8:0] = ddis_reg;
            default: begin
               if (avs_address[7:6] == `ARS_RES_SEL) begin
                  rdat_next = {15'h0, val_reg[avs_address[5]][avs_address[4:2]],
                     res_reg[avs_address[5]][avs_address[4:2]]};
               end
            end
         endcase
      end

      // bus access takes effect at the edge with waitrequest low
      if (ack_reg && avs_write) begin
         case (avs_address)
            `ARS_CTRL: ctrl_next = avs_writedata[9:0];
            `ARS_TIME: time_next = avs_writedata[15:0];
            `ARS_PMASK: begin
               pmask_next = avs_writedata[8:0];
               xmux_next = avs_writedata[14:12];
               if (avs_writedata[`ARS_SWGO]) pend_next = avs_writedata[8:0];
            end
            `ARS_INSERT: begin
               insv_next = 1'b1;
               ins_next = avs_writedata[6:0];
            end
            `ARS_PRIO: prio_next = avs_writedata[3:0];
            `ARS_TRIG: trig_next = avs_writedata[1:0];
            `ARS_LIMIT: begin
               lo_next = avs_writedata[9:0];
               hi_next = avs_writedata[25:16];
            end
            `ARS_STATUS: flag_next = flag_reg & ~avs_writedata[3:0];
            `ARS_WFR: wfr_next = avs_writedata[7:0];
            `ARS_DDIS: ddis_next = avs_writedata[8:0];
            default: ;
         endcase
      end
      if (ack_reg && avs_read) begin
         if (avs_address == `ARS_POP0 || avs_address == `ARS_POP1) begin
            rk = {1'b0, avs_address == `ARS_POP1};
            val_next[rk[0]][rp_reg[rk[0]]] = 1'b0; // FIFO pop
            rp_next[rk[0]] = rp_reg[rk[0]] + 3'h1;
         end else if (avs_address[7:6] == `ARS_RES_SEL) begin
            val_next[avs_address[5]][avs_address[4:2]] = 1'b0;
         end
      end

      // trigger events
      if (trig_in[0] && trig_reg[0]) pend_next = pmask_reg;
      if (trig_in[1] && trig_reg[1]) qgo_next = 1'b1;

      // remove the granted request from its source
      if (grant) begin
         sq_next = SQ_WAIT;
         // only a converter that starts moves its select
         if (to0) ch_next[0] = gent[3:0];
         if (to1) ch_next[1] = ch1;
         xmux_next = ctrl_reg[`ARS_C_XMUX] ? gent[6:4] : xmux_reg;
         case (src)
            SRC_INS: insv_next = 1'b0;
            SRC_PAR: begin
               pend_next[gent[3:0]] = 1'b0;
               if (pend_next == 9'h000) flag_next[`ARS_F_SEQ] = 1'b1;
            end
            SRC_Q: begin
               for (int i = 0; i < 3; i++) q_next[i] = q_reg[i + 1];
               qcnt_next = qcnt_reg - 3'h1;
               if (qcnt_next == 3'h0) begin
                  qgo_next = 1'b0;
                  flag_next[`ARS_F_SEQ] = 1'b1;
               end
            end
            default: ;
         endcase
      end else if (sq_reg == SQ_WAIT && busy == 2'b00) begin
         sq_next = SQ_IDLE;
      end

      // queue push after any pop in the same cycle
      if (ack_reg && avs_write && avs_address == `ARS_QUEUE) begin
         if (qcnt_next < `ARS_QDEPTH) begin
            q_next[qcnt_next[1:0]] = avs_writedata[6:0];
            qcnt_next = qcnt_next + 3'h1;
         end else begin
            flag_next[`ARS_F_QOVF] = 1'b1;
         end
      end

      // result reduction and storage, store wins over a read clear
      for (int k = 0; k < 2; k++) begin
         if (done[k]) begin
            s_slot = slot(ctrl_reg[`ARS_C_CHAIN], wp_reg[k], ch_reg[k]);
            nv = {6'h00, cres[k]};
            if (acc && val_reg[k][s_slot]) begin
               nv = res_reg[k][s_slot] + nv; // accumulate
            end
            if (!ctrl_reg[`ARS_C_LIM] ||
                cres[k] < lo_reg || cres[k] > hi_reg) begin
               res_next[k][s_slot] = nv;
               val_next[k][s_slot] = 1'b1;
               if (ctrl_reg[`ARS_C_CHAIN] &&
                   !(acc && val_reg[k][s_slot])) begin
                  wp_next[k] = wp_reg[k] + 3'h1;
               end
               evt_next = 1'b1;
               flag_next[`ARS_F_RES] = 1'b1;
               if (ctrl_reg[`ARS_C_LIM]) flag_next[`ARS_F_LIM] = 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sq_reg <= SQ_IDLE;
         ctrl_reg <= `ARS_CTRL_RST;
         time_reg <= `ARS_TIME_RST;
         pmask_reg <= 9'h000;
         pend_reg <= 9'h000;
         q_reg <= '{default: 7'h00};
         qcnt_reg <= 3'h0;
         qgo_reg <= 1'b0;
         insv_reg <= 1'b0;
         ins_reg <= 7'h00;
         prio_reg <= 4'h0;
         trig_reg <= 2'h0;
         {hi_reg, lo_reg} <= `ARS_LIM_RST;
         flag_reg <= 4'h0;
         wfr_reg <= 8'h00;
         ddis_reg <= 9'h000;
         res_reg <= '{default: '{default: 16'h0000}};
         val_reg <= '{default: 8'h00};
         wp_reg <= '{default: 3'h0};
         rp_reg <= '{default: 3'h0};
         ch_reg <= '{default: 4'h0};
         xmux_reg <= 3'h0;
         ack_reg <= 1'b0;
         evt_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
         pwr_reg <= 2'h0;
         bw_reg <= 2'h0;
      end else begin
         sq_reg <= sq_next;
         ctrl_reg <= ctrl_next;
         time_reg <= time_next;
         pmask_reg <= pmask_next;
         pend_reg <= pend_next;
         q_reg <= q_next;
         qcnt_reg <= qcnt_next;
         qgo_reg <= qgo_next;
         insv_reg <= insv_next;
         ins_reg <= ins_next;
         prio_reg <= prio_next;
         trig_reg <= trig_next;
         lo_reg <= lo_next;
         hi_reg <= hi_next;
         flag_reg <= flag_next;
         wfr_reg <= wfr_next;
         ddis_reg <= ddis_next;
         res_reg <= res_next;
         val_reg <= val_next;
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         ch_reg <= ch_next;
         xmux_reg <= xmux_next;
         ack_reg <= ack_next;
         evt_reg <= evt_next;
         rdat_reg <= rdat_next;
         pwr_reg <= pwr_next;
         bw_reg <= bw_next;
      end
   end

   // outputs straight from flip-flops
   assign avs_readdata = rdat_reg;
   assign avs_waitrequest = !ack_reg;
   assign mux_sel0 = ch_reg[0];
   assign mux_sel1 = ch_reg[1];
   assign ext_mux_sel = xmux_reg;
   assign conv_pwr = pwr_reg;
   assign bw_precharge = bw_reg;
   assign mux_test = ctrl_reg[`ARS_C_MTEST];
   assign din_disable = ddis_reg;
   assign evt_req = evt_reg;
endmodule

// ### rtl/ars_defs.svh
// register offsets, field positions, reset values for the adc sequencer
`ifndef ARS_DEFS_SVH
`define ARS_DEFS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ARS_CTRL 8'h00
`define ARS_TIME 8'h04
`define ARS_PMASK 8'h08
`define ARS_QUEUE 8'h0C
`define ARS_INSERT 8'h10
`define ARS_PRIO 8'h14
`define ARS_TRIG 8'h18
`define ARS_LIMIT 8'h1C
`define ARS_STATUS 8'h20
`define ARS_POP0 8'h24
`define ARS_POP1 8'h28
`define ARS_WFR 8'h2C
`define ARS_DDIS 8'h30
`define ARS_RES_SEL 2'h1
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define ARS_C_RES8 0
`define ARS_C_SYNC 1
`define ARS_C_CHAIN 2
`define ARS_C_LIM 3
`define ARS_C_ACC 4
`define ARS_C_MTEST 5
`define ARS_C_BWD 6
`define ARS_C_SH2 7
`define ARS_C_SYCH 8
`define ARS_C_XMUX 9
`define ARS_SWGO 31
// ----------------------------------------------------------------
// flag positions and sizes
// ----------------------------------------------------------------
`define ARS_F_RES 0
`define ARS_F_LIM 1
`define ARS_F_SEQ 2
`define ARS_F_QOVF 3
`define ARS_NCH 9
`define ARS_QDEPTH 3'h4
`define ARS_SHARED 4'h7
`define ARS_BITS10 4'h9
`define ARS_BITS8 4'h7
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ARS_CTRL_RST 10'h000
`define ARS_TIME_RST 16'h0303
`define ARS_LIM_RST 20'hFFC00
`endif

// ### rtl/ars_pkg.sv
// types shared by the adc request sequencer
package ars_pkg;
   typedef enum logic [1:0] {SQ_IDLE = 2'b01, SQ_WAIT = 2'b10} ars_seq_t;
   typedef enum logic [2:0] {
      CV_OFF = 3'b001,
      CV_SMP = 3'b010,
      CV_CNV = 3'b100
   } ars_conv_t;
   typedef logic [15:0] ars_res_t;
   typedef logic [6:0] ars_qent_t;
   typedef enum logic [1:0] {
      SRC_NONE = 2'h0, SRC_INS = 2'h1, SRC_PAR = 2'h2, SRC_Q = 2'h3
   } ars_src_t;
endpackage

// ### rtl/ars_conv.sv
// one successive approximation converter timing engine
`timescale 1ns/10ps
`include "ars_defs.svh"
module ars_conv import ars_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic res8,
   input wire logic [7:0] smp_cyc,
   input wire logic [7:0] cnv_cyc,
   input wire logic [9:0] ana,
   output logic busy,
   output logic sampling,
   output logic done,
   output logic [9:0] result
);
   ars_conv_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [3:0] bit_reg, bit_next;
   logic [9:0] sar_reg, sar_next, hold_reg, hold_next, trial, cmp;
   logic mode_reg, mode_next;

   // ----------------------------------------------------------------
   // sample, then one trial bit per conversion step
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      sar_next = sar_reg;
      hold_next = hold_reg;
      mode_next = mode_reg;
      done = 1'b0;
      trial = sar_reg | (10'h001 << bit_reg);
      cmp = mode_reg ? {2'h0, hold_reg[9:2]} : hold_reg;
      case (state_reg)
         CV_OFF: begin
            if (start) begin // wake on request
               state_next = CV_SMP;
               cnt_next = smp_cyc;
               mode_next = res8;
            end
         end
         CV_SMP: begin
            if (cnt_reg == 8'h00) begin
               hold_next = ana;
               state_next = CV_CNV;
               cnt_next = cnv_cyc;
               bit_next = mode_reg ? `ARS_BITS8 : `ARS_BITS10;
               sar_next = 10'h000;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         CV_CNV: begin
            if (cnt_reg == 8'h00) begin
               if (cmp >= trial) begin
                  sar_next = trial;
               end
               if (bit_reg == 4'h0) begin
                  done = 1'b1;
                  state_next = CV_OFF; // power down when idle
               end else begin
                  bit_next = bit_reg - 4'h1;
                  cnt_next = cnv_cyc;
               end
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         default: state_next = CV_OFF;
      endcase
   end

   assign busy = (state_reg != CV_OFF);
   assign sampling = (state_reg == CV_SMP);
   assign result = sar_next;

   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= CV_OFF;
         cnt_reg <= 8'h00;
         bit_reg <= 4'h0;
         sar_reg <= 10'h000;
         hold_reg <= 10'h000;
         mode_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         sar_reg <= sar_next;
         hold_reg <= hold_next;
         mode_reg <= mode_next;
      end
   end
endmodule

// ### testbench/ars_checker.sv
// port assertions for the adc request sequencer
`timescale 1ns/10ps
module ars_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic evt_req,
   input wire logic [1:0] conv_pwr,
   input wire logic [1:0] bw_precharge,
   input wire logic [8:0] din_disable,
   input wire logic mux_test,
   input wire logic [3:0] mux_sel0
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // bus handshake steps
   // ----------------------------------------------------------------
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_wait_one: assert property (s_req |=> s_ack)
      else $error("access not answered after one wait");
   a_idle_wait: assert property (!(avs_read || avs_write) &&
      avs_waitrequest |=> avs_waitrequest)
      else $error("answer without a request");
   a_rd_hold: assert property (!(avs_read || avs_write)
      |=> $stable(avs_readdata))
      else $error("read data moved without a request");
   // ----------------------------------------------------------------
   // converter side relations
   // ----------------------------------------------------------------
   a_evt_power: assert property (evt_req |->
      $past(conv_pwr) != 2'h0)
      else $error("result event with converters idle");
   a_bw_power: assert property (bw_precharge != 2'h0 |->
      (bw_precharge & ~conv_pwr) == 2'h0)
      else $error("precharge on an unpowered converter");
   a_ddis_write: assert property ($changed(din_disable) |->
      $past(avs_write) || $past(avs_write, 2))
      else $error("input disable changed without a write");
   a_mtest_write: assert property ($changed(mux_test) |->
      $past(avs_write) || $past(avs_write, 2))
      else $error("mux test changed without a write");
   a_sel_power: assert property ($changed(mux_sel0) |->
      ##[0:2] conv_pwr[0])
      else $error("channel selected but converter not woken");
endmodule
bind ars_top ars_checker chk_u (.*);

// ### testbench/ars_analog.sv
// analog source model behind both converter inputs
`timescale 1ns/10ps
module ars_analog (
   input wire logic clk,
   input wire logic [1:0] conv_pwr,
   input wire logic [3:0] mux_sel0,
   input wire logic [3:0] mux_sel1,
   input wire logic [9:0] base,
   output logic [9:0] ana0 = 10'h000,
   output logic [9:0] ana1 = 10'h000
);
   // selected source gives base xor channel; idle inputs wander
   always @(posedge clk) begin
      ana0 <= conv_pwr[0] ? base ^ {6'h00, mux_sel0} : ~ana0;
      ana1 <= conv_pwr[1] ? base ^ {6'h00, mux_sel1} : ~ana1;
   end
endmodule

// ### testbench/ars_top_tb.sv
// self-checking bench for the adc request sequencer
`timescale 1ns/10ps
`include "ars_defs.svh"
module ars_top_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, v;
   logic avs_waitrequest, mux_test, evt_req;
   logic [1:0] trig_in = 2'h0;
   logic [9:0] ana0, ana1, a_val;
   logic [9:0] base = 10'h000;
   logic [3:0] mux_sel0, mux_sel1;
   logic [3:0] qch[3] = '{4'h2, 4'h0, 4'h1};
   logic [2:0] ext_mux_sel;
   logic [1:0] conv_pwr, bw_precharge;
   logic [8:0] din_disable;
   logic [31:0] exp_q[$];
   int n_fail = 0, num_checks = 0, n_evt = 0, seed = 32'hAD6BC1D7;
   ars_top dut_u (.*);
   ars_analog src_u (.*);
   always #10 clk = ~clk;
   // ----------------------------------------------------------------
   // compare, bus and wait helpers
   // ----------------------------------------------------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic hang;
      n_fail++;
      print_verdict();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("[FAIL] t=%0t seen %h want %h", $time, seen, want);
      end
   endtask
   function automatic logic [31:0] res(input logic [9:0] x);
      return {15'h0, 1'b1, 6'h00, x};
   endfunction
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (i == 50)
         hang();
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wait_evt(input int n);
      for (int i = 0; i < 3000 && n_evt < n; i++)
         @(posedge clk);
      if (n_evt < n)
         hang();
   endtask
   // scoreboard: each answer against the oldest note, events counted
   always @(posedge clk) begin
      if (evt_req === 1'b1)
         n_evt++;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         check(avs_readdata, exp_q.size() ? exp_q.pop_front() : 32'hDEAD);
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`ARS_CTRL, 32'h0);
      rd(`ARS_TIME, 32'h0303);
      rd(`ARS_LIMIT, 32'h03FF0000);
      rd(8'h84, 32'h0);
      v = $random(seed);
      bus(1'b1, `ARS_DDIS, v);
      rd(`ARS_DDIS, {23'h0, v[8:0]});
      bus(1'b1, `ARS_CTRL, 32'h24);
      repeat (2) @(posedge clk);
      check({23'h0, din_disable}, {23'h0, v[8:0]});
      check({31'h0, mux_test}, 32'h1);
      // queued entries in software order through the chained fifo
      bus(1'b1, `ARS_TIME, 32'h0003);
      base <= $random(seed);
      for (int k = 0; k < 3; k++)
         bus(1'b1, `ARS_QUEUE, {28'h0, qch[k]});
      wait_evt(3);
      for (int k = 0; k < 3; k++)
         rd(`ARS_POP0, {22'h0, base ^ {6'h00, qch[k]}});
      // triggered parallel load converts lowest channel first
      bus(1'b1, `ARS_TRIG, 32'h1);
      bus(1'b1, `ARS_PMASK, 32'h30);
      trig_in <= 2'h1;
      @(posedge clk);
      trig_in <= 2'h0;
      wait_evt(5);
      rd(`ARS_POP0, {22'h0, base ^ 10'h004});
      rd(`ARS_POP0, {22'h0, base ^ 10'h005});
      // short mode keeps the top eight bits
      bus(1'b1, `ARS_CTRL, 32'h5);
      bus(1'b1, `ARS_QUEUE, 32'h3);
      wait_evt(6);
      a_val = base ^ 10'h003;
      rd(`ARS_POP0, {24'h0, a_val[9:2]});
      // wait-for-read holds the second result until the first is read
      bus(1'b1, `ARS_CTRL, 32'h0);
      bus(1'b1, `ARS_WFR, 32'h2);
      bus(1'b1, `ARS_QUEUE, 32'h1);
      wait_evt(7);
      a_val = base ^ 10'h001;
      base <= ~base;
      bus(1'b1, `ARS_QUEUE, 32'h1);
      repeat (40) @(posedge clk);
      check(n_evt, 32'd7);
      rd(8'h44, res(a_val));
      wait_evt(8);
      rd(8'h44, res(~a_val));
      // inserted entry in sync mode: both selects and the ext mux move
      bus(1'b1, `ARS_CTRL, 32'h342);
      bus(1'b1, `ARS_INSERT, 32'h53);
      wait_evt(9);
      check({21'h0, ext_mux_sel, mux_sel1, mux_sel0}, 32'h583);
      rd(8'h4C, res(base ^ 10'h003));
      rd(8'h60, res(base ^ 10'h008));
      print_verdict();
   end
endmodule
